// ### logic/tsc_timestamp_capture.sv
// Function
// - Wide counter steps once per sample clock
// - Clear on software command, or on card start in start-clear mode
// - Each trigger pushes counter into FIFO
// - Gate open and gate close each stamped
// - In full-width mode stamp bits 55:0 equal samples since last clear
// - Mode codes off, explicit, start-clear
// - Start-clear mode clears at card start
// - Clear command latches time and date
// - Source 100h counts full width
// - Source 200h splits, upper on rising ref
// - Source 400h splits, upper on falling ref
// - Aux inputs fill upper byte when enabled
// - Upper byte zero when aux capture off
// - No extra stamps without feature bit
// - Feature 10000h stamps every slow-area sample
// - Time register hours, minutes, seconds fields
// - Date register year, month, day fields
// - Millisecond limit on reference edge wait
// - Read-only capability bitmap of modes
// - Clear command zeroes counter only while clocks run; card-start clear acts regardless
// - Every stamp is 64 bits
// - Ref edge clears lower, bumps upper
// - Clear zeroes both split parts
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module tsc_timestamp_capture #(
	parameter int unsigned MS_CYCLES = tsc_pkg::MS_CYCLES
) (
	input  wire logic                         CLOCK_I,
	input  wire logic                         RST_N_I,
	input  wire logic                         CE_I,
	input  wire logic                         SAMPLE_EN_I,
	input  wire logic                         CLOCK_RUNNING_I,
	input  wire logic                         CARD_START_I,
	input  wire logic                         TRIGGER_I,
	input  wire logic                         GATE_I,
	input  wire logic                         SLOW_AREA_I,
	input  wire logic                         REF_CLK_I,
	input  wire logic [tsc_pkg::AUX_W-1:0]    AUX_I,
	input  wire logic [tsc_pkg::ADDR_W-1:0]   AVS_ADDRESS_I,
	input  wire logic                         AVS_READ_I,
	input  wire logic                         AVS_WRITE_I,
	input  wire logic [31:0]                  AVS_WRITEDATA_I,
	input  wire logic [3:0]                   AVS_BYTEENABLE_I,
	output logic      [31:0]                  AVS_READDATA_O,
	output logic                              AVS_WAITREQUEST_O,
	output logic                              STAMP_PENDING_O
);
	import tsc_pkg::*;

	logic [31:0]          cmd;
	logic [31:0]          time_stage;
	logic [31:0]          date_stage;
	logic [31:0]          time_latched;
	logic [31:0]          date_latched;
	logic [31:0]          wait_limit;
	logic [STAMP_W-1:0]   cnt;
	logic                 ref_prev;
	logic                 gate_prev;
	logic [15:0]          ms_div;
	logic [31:0]          wait_ms;
	logic                 overflow;
	logic                 ref_timeout;
	logic [FIFO_AW:0]     wr_ptr;
	logic [FIFO_AW:0]     rd_ptr;
	logic [STAMP_W-1:0]   head;
	logic [31:0]          next_readdata;
	logic [15:0]          idx;
	logic                 wr_acc;
	logic                 rd_acc;
	logic                 clear_cmd;
	logic                 clear_eff;
	logic                 start_clear;
	logic                 enabled;
	logic                 split;
	logic                 ref_edge;
	logic                 aux_on;
	logic                 gate_edge;
	logic                 stamp_event;
	logic [STAMP_W-1:0]   stamp_val;
	logic [FIFO_AW:0]     fill;
	logic                 full;
	logic                 empty;
	logic                 push;
	logic                 pop;
	logic [FIFO_AW:0]     next_rd_ptr;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Bus decode; a write or read takes effect when waitrequest is seen low
	assign idx    = AVS_ADDRESS_I[ADDR_W-1:2];
	assign wr_acc = AVS_WRITE_I && !AVS_WAITREQUEST_O;
	assign rd_acc = AVS_READ_I && !AVS_WAITREQUEST_O;

	assign enabled = (cmd & (MODE_EXPLICIT | MODE_START_CLEAR)) != MODE_OFF;
	// split on rising or falling reference edge
	assign split   = (cmd & (SRC_SPLIT_RISE | SRC_SPLIT_FALL)) != 32'h0;
	assign aux_on  = (cmd & FEAT_AUX_CAPTURE) != 32'h0;

	assign ref_edge = (((cmd & SRC_SPLIT_RISE) != 32'h0) && REF_CLK_I && !ref_prev)
		|| (((cmd & SRC_SPLIT_FALL) != 32'h0) && !REF_CLK_I && ref_prev);

	assign clear_cmd   = wr_acc && idx == IDX_CMD && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[0];
	// ignored while the card clocks are stopped
	assign clear_eff   = clear_cmd && CLOCK_RUNNING_I;
	// start-clear mode zeroes at each card start
	assign start_clear = CARD_START_I && (cmd & MODE_START_CLEAR) != 32'h0;

	assign gate_edge   = GATE_I != gate_prev;
	// extra stamp only with its feature bit
	// slow-area stamp on its feature bit
	assign stamp_event = TRIGGER_I || gate_edge || (SLOW_AREA_I && (cmd & FEAT_SLOW_FIRST) != 32'h0);
	// aux byte or zero extension in the top byte
	// zero top byte when capture off
	assign stamp_val   = {aux_on ? AUX_I : {AUX_W{1'b0}}, cnt[AUX_LSB-1:0]};

	assign fill  = wr_ptr - rd_ptr;
	assign full  = fill[FIFO_AW];
	assign empty = wr_ptr == rd_ptr;
	assign push  = enabled && stamp_event && !full;
	assign pop   = rd_acc && idx == IDX_STAMP_HI && !empty;
	assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

	// Avalon answer: one wait cycle, then readdata with waitrequest low
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O    <= 32'h0;
		end else if (CE_I) begin
			AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
			if (AVS_READ_I && AVS_WAITREQUEST_O) begin
				AVS_READDATA_O <= next_readdata;
			end
		end
	end

	always_comb begin
		next_readdata = 32'h0;
		case (idx)
			IDX_CMD:        next_readdata = cmd;
			IDX_CAPS:       next_readdata = CAPS_VALUE;
			IDX_TIME:       next_readdata = time_latched;
			IDX_DATE:       next_readdata = date_latched;
			IDX_WAIT_LIMIT: next_readdata = wait_limit;
			IDX_STATUS: begin
				next_readdata[ST_EMPTY]                      = empty;
				next_readdata[ST_OVERFLOW]                   = overflow;
				next_readdata[ST_REF_TIMEOUT]                = ref_timeout;
				next_readdata[ST_COUNT_LSB +: FIFO_AW + 1]   = fill;
			end
			IDX_STAMP_LO:   next_readdata = empty ? 32'h0 : head[31:0];
			IDX_STAMP_HI:   next_readdata = empty ? 32'h0 : head[STAMP_W-1:32];
			default:        next_readdata = 32'h0;
		endcase
	end

	// one write holds mode, source and features; clear bit is not stored
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cmd <= CMD_RESET;
		end else if (CE_I && wr_acc && idx == IDX_CMD) begin
			cmd <= merge(cmd, AVS_WRITEDATA_I, AVS_BYTEENABLE_I) & CMD_STORE_MASK;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wait_limit <= LIMIT_RESET;
		end else if (CE_I && wr_acc && idx == IDX_WAIT_LIMIT) begin
			wait_limit <= merge(wait_limit, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
		end
	end

	// Host writes land in staging; readback shows the copy taken at the last clear command
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			time_stage   <= TIME_RESET;
			date_stage   <= DATE_RESET;
			time_latched <= TIME_RESET;
			date_latched <= DATE_RESET;
		end else if (CE_I) begin
			if (wr_acc && idx == IDX_TIME) begin
				time_stage <= merge(time_stage, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end
			if (wr_acc && idx == IDX_DATE) begin
				date_stage <= merge(date_stage, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end
			if (clear_cmd) begin
				// hours, minutes, seconds; top byte reserved
				time_latched <= {8'h0,
					time_stage[TIME_HOUR_LSB +: FIELD_W],
					time_stage[TIME_MIN_LSB +: FIELD_W],
					time_stage[TIME_SEC_LSB +: FIELD_W]};
				date_latched <= {date_stage[DATE_YEAR_LSB +: YEAR_W],
					date_stage[DATE_MON_LSB +: FIELD_W],
					date_stage[DATE_DAY_LSB +: FIELD_W]};
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ref_prev  <= 1'b0;
			gate_prev <= 1'b0;
		end else if (CE_I) begin
			ref_prev  <= REF_CLK_I;
			gate_prev <= GATE_I;
		end
	end

	// Counter; clear wins over any step in the same cycle
	// wide sample counter
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cnt <= '0;
		end else if (CE_I) begin
			// clear paths; both split parts zeroed
			if (clear_eff || start_clear) begin
				cnt <= '0;
			end else if (split && ref_edge) begin
				cnt[STAMP_W-1:SPLIT_W] <= cnt[STAMP_W-1:SPLIT_W] + 1'b1;
				cnt[SPLIT_W-1:0]       <= '0;
			// sample enable is the non-interlaced rate
			end else if (SAMPLE_EN_I) begin
				// lower part only in split mode
				if (split) begin
					cnt[SPLIT_W-1:0] <= cnt[SPLIT_W-1:0] + 1'b1;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end
	end

	// milliseconds since the last reference edge
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ms_div  <= 16'h0;
			wait_ms <= 32'h0;
		end else if (CE_I) begin
			if (!split || ref_edge || clear_eff) begin
				ms_div  <= 16'h0;
				wait_ms <= 32'h0;
			end else if (ms_div == 16'(MS_CYCLES - 1)) begin
				ms_div <= 16'h0;
				if (wait_ms != 32'hffff_ffff) begin
					wait_ms <= wait_ms + 32'h1;
				end
			end else begin
				ms_div <= ms_div + 16'h1;
			end
		end
	end

	// Sticky flags, cleared by writing one; a new event wins over the clear
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			overflow    <= 1'b0;
			ref_timeout <= 1'b0;
		end else if (CE_I) begin
			if (enabled && stamp_event && full) begin
				overflow <= 1'b1;
			end else if (wr_acc && idx == IDX_STATUS && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[ST_OVERFLOW]) begin
				overflow <= 1'b0;
			end
			if (split && wait_limit != 32'h0 && wait_ms >= wait_limit) begin
				ref_timeout <= 1'b1;
			end else if (wr_acc && idx == IDX_STATUS && AVS_BYTEENABLE_I[0]
				&& AVS_WRITEDATA_I[ST_REF_TIMEOUT]) begin
				ref_timeout <= 1'b0;
			end
		end
	end

	// FIFO pointers; the stamp is the count before this cycle's step
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_ptr          <= '0;
			rd_ptr          <= '0;
			STAMP_PENDING_O <= 1'b0;
		end else if (CE_I) begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			rd_ptr          <= next_rd_ptr;
			STAMP_PENDING_O <= (wr_ptr + (push ? 1'b1 : 1'b0)) != next_rd_ptr;
		end
	end

	tsc_stamp_mem u_mem (
		.clk_i   (CLOCK_I),
		.ce_i    (CE_I),
		.we_i    (push),
		.waddr_i (wr_ptr[FIFO_AW-1:0]),
		.wdata_i (stamp_val),
		.raddr_i (next_rd_ptr[FIFO_AW-1:0]),
		.rdata_o (head)
	);

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);

	chk_full_step: assert property (
		CE_I && SAMPLE_EN_I && !split && !clear_eff && !start_clear |=> cnt == $past(cnt) + 64'h1)
		else $error("full counter did not step by one");
	chk_clear_cmd: assert property (
		CE_I && clear_eff |=> cnt == '0)
		else $error("clear command did not zero counter");
	chk_start_clear: assert property (
		CE_I && CARD_START_I && (cmd & MODE_START_CLEAR) != 32'h0 |=> cnt == '0)
		else $error("card start did not zero counter");
	chk_ref_split: assert property (
		CE_I && split && ref_edge && !clear_eff && !start_clear
		|=> cnt[SPLIT_W-1:0] == '0 && cnt[STAMP_W-1:SPLIT_W] == $past(cnt[STAMP_W-1:SPLIT_W]) + 32'h1)
		else $error("ref edge did not advance upper part");
	chk_off_no_push: assert property (
		CE_I && !enabled && !pop |=> fill == $past(fill))
		else $error("stamp pushed while disabled");
	chk_trig_push: assert property (
		CE_I && enabled && TRIGGER_I && !full && !pop |=> fill == $past(fill) + 1'b1)
		else $error("trigger did not add a stamp");
	chk_gate_edges: assert property (
		CE_I && enabled && GATE_I != gate_prev && !full && !pop |=> fill == $past(fill) + 1'b1)
		else $error("gate edge not stamped");
	chk_aux_byte: assert property (
		CE_I && push && empty |=> head[STAMP_W-1:AUX_LSB] == ($past(aux_on) ? $past(AUX_I) : 8'h00))
		else $error("stamp top byte wrong");
	chk_bus_answer: assert property (
		CE_I && (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
		|=> !AVS_WAITREQUEST_O ##1 (AVS_WAITREQUEST_O || !$past(CE_I)))
		else $error("bus answer not one cycle late");

	cov_trigger: cover property (CE_I && push && TRIGGER_I);
	cov_gate: cover property (CE_I && push && gate_edge);
	cov_ref_edge: cover property (CE_I && split && ref_edge);
	cov_overflow: cover property (CE_I && enabled && stamp_event && full);
endmodule

// ### logic/tsc_pkg.sv
package tsc_pkg;
	// Register indices; byte address is four times the index
	localparam int          ADDR_W         = 18;
	localparam logic [15:0] IDX_CMD        = 16'hb798;
	localparam logic [15:0] IDX_CAPS       = 16'hb799;
	localparam logic [15:0] IDX_TIME       = 16'hb7b6;
	localparam logic [15:0] IDX_DATE       = 16'hb7b7;
	localparam logic [15:0] IDX_WAIT_LIMIT = 16'hb7c5;
	localparam logic [15:0] IDX_STATUS     = 16'hb7d0;
	localparam logic [15:0] IDX_STAMP_LO   = 16'hb7d1;
	localparam logic [15:0] IDX_STAMP_HI   = 16'hb7d2;

	// Command codes, ORed together by software
	localparam logic [31:0] CMD_CLEAR        = 32'h0000_0001;
	localparam logic [31:0] MODE_OFF         = 32'h0000_0000;
	localparam logic [31:0] MODE_EXPLICIT    = 32'h0000_0002;
	localparam logic [31:0] MODE_START_CLEAR = 32'h0000_0004;
	localparam logic [31:0] SRC_FULL         = 32'h0000_0100;
	localparam logic [31:0] SRC_SPLIT_RISE   = 32'h0000_0200;
	localparam logic [31:0] SRC_SPLIT_FALL   = 32'h0000_0400;
	localparam logic [31:0] FEAT_AUX_CAPTURE = 32'h0000_1000;
	localparam logic [31:0] FEAT_SLOW_FIRST  = 32'h0001_0000;
	localparam logic [31:0] CMD_RESET        = 32'h0000_0000;
	localparam logic [31:0] CMD_STORE_MASK   = MODE_EXPLICIT | MODE_START_CLEAR | SRC_FULL | SRC_SPLIT_RISE
		| SRC_SPLIT_FALL | FEAT_AUX_CAPTURE | FEAT_SLOW_FIRST;
	localparam logic [31:0] CAPS_VALUE       = CMD_STORE_MASK | CMD_CLEAR;

	// Stamp layout
	localparam int STAMP_W  = 64;
	localparam int SPLIT_W  = 32;
	localparam int AUX_W    = 8;
	localparam int AUX_LSB  = 56;
	localparam int FIFO_AW  = 4;

	// Time of day and calendar fields
	localparam int          FIELD_W       = 8;
	localparam int          TIME_SEC_LSB  = 0;
	localparam int          TIME_MIN_LSB  = 8;
	localparam int          TIME_HOUR_LSB = 16;
	localparam int          DATE_DAY_LSB  = 0;
	localparam int          DATE_MON_LSB  = 8;
	localparam int          DATE_YEAR_LSB = 16;
	localparam int          YEAR_W        = 16;
	localparam logic [31:0] TIME_RESET    = 32'h0000_0000;
	localparam logic [31:0] DATE_RESET    = 32'h0000_0000;
	localparam logic [31:0] LIMIT_RESET   = 32'h0000_0000;

	// Status bits
	localparam int ST_EMPTY       = 0;
	localparam int ST_OVERFLOW    = 1;
	localparam int ST_REF_TIMEOUT = 2;
	localparam int ST_COUNT_LSB   = 8;

	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
endpackage

// ### logic/tsc_stamp_mem.sv
`timescale 1ns/1ps
module tsc_stamp_mem (
	input  wire logic                                clk_i,
	input  wire logic                                ce_i,
	input  wire logic                                we_i,
	input  wire logic [tsc_pkg::FIFO_AW-1:0]         waddr_i,
	input  wire logic [tsc_pkg::STAMP_W-1:0]         wdata_i,
	input  wire logic [tsc_pkg::FIFO_AW-1:0]         raddr_i,
	output logic      [tsc_pkg::STAMP_W-1:0]         rdata_o
);
	import tsc_pkg::*;

	logic [STAMP_W-1:0] mem [2**FIFO_AW];

	always_ff @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Write-first so a stamp entering an empty FIFO is readable at once
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (we_i && waddr_i == raddr_i) begin
				rdata_o <= wdata_i;
			end else begin
				rdata_o <= mem[raddr_i];
			end
		end
	end
endmodule

// ### dv/tsc_acq_model.sv
`timescale 1ns/1ps
module tsc_acq_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       quiet_i,
	input  wire logic       start_i,
	output logic            sample_en_o,
	output logic            trigger_o,
	output logic            gate_o,
	output logic            slow_o,
	output logic            card_start_o,
	output logic            ref_clk_o,
	output logic [7:0]      aux_o
);
	integer seed = 32'hc2de9867;
	integer r;
	int     ref_cnt;

	// Sequencer halts sampling, triggers and the reference while the host reconfigures
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sample_en_o  <= 1'b0;
			trigger_o    <= 1'b0;
			gate_o       <= 1'b0;
			slow_o       <= 1'b0;
			card_start_o <= 1'b0;
			ref_clk_o    <= 1'b0;
			aux_o        <= 8'h00;
			ref_cnt = 0;
		end else begin
			r = $random(seed);
			aux_o        <= r[31:24];
			card_start_o <= start_i;
			if (quiet_i) begin
				sample_en_o <= 1'b0;
				trigger_o   <= 1'b0;
				slow_o      <= 1'b0;
			end else begin
				sample_en_o <= r[0] | r[1];
				trigger_o   <= (r[4:2] == 3'h0);
				slow_o      <= (r[8:5] == 4'h0);
				if (r[12:9] == 4'h0) begin
					gate_o <= !gate_o;
				end
				ref_cnt = ref_cnt + 1;
				if (ref_cnt == 7) begin
					ref_cnt = 0;
					ref_clk_o <= !ref_clk_o;
				end
			end
		end
	end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, (e), (g)); end end
module tb_top;
	import tsc_pkg::*;
	logic               clk;
	logic               rst_n;
	logic               running;
	logic               quiet;
	logic               ce;
	logic [3:0]         avs_be;
	logic               start;
	logic               sample_en, trigger, gate, slow, card_start, ref_clk;
	logic [7:0]         aux;
	logic [ADDR_W-1:0]  avs_address;
	logic               avs_read, avs_write;
	logic [31:0]        avs_writedata, avs_readdata, v;
	logic               avs_waitrequest, stamp_pending;
	int                 num_errors = 0;
	int                 n_checks = 0;
	logic [63:0]        m_cnt;
	logic [63:0]        m_q[$];
	logic [31:0]        m_cmd, m_stage_t, m_stage_d, m_time, m_date;
	logic               m_ref_q, m_gate_q, m_ovf, m_edge;
	logic [31:0]        cfg[7] = '{MODE_EXPLICIT | SRC_FULL, MODE_START_CLEAR | SRC_FULL | FEAT_AUX_CAPTURE,
		MODE_EXPLICIT | SRC_SPLIT_RISE | FEAT_SLOW_FIRST, MODE_START_CLEAR | SRC_SPLIT_FALL | FEAT_AUX_CAPTURE
		| FEAT_SLOW_FIRST, MODE_EXPLICIT | SRC_FULL, MODE_OFF | SRC_FULL, MODE_START_CLEAR | SRC_SPLIT_RISE};
	logic               run[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
	int                 len[7] = '{40, 40, 60, 200, 40, 40, 60};
	logic [15:0]        rst_idx[6] = '{IDX_CMD, IDX_CAPS, IDX_TIME, IDX_DATE, IDX_WAIT_LIMIT, IDX_STATUS};
	logic [31:0]        rst_val[6] = '{CMD_RESET, CAPS_VALUE, TIME_RESET, DATE_RESET, LIMIT_RESET, 32'h0000_0001};
	wire                bus_wr = avs_write && (avs_waitrequest === 1'b0);
	wire [15:0]         bus_idx = avs_address[17:2];

	tsc_timestamp_capture #(.MS_CYCLES(10)) i_dut (
		.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .SAMPLE_EN_I(sample_en), .CLOCK_RUNNING_I(running),
		.CARD_START_I(card_start), .TRIGGER_I(trigger), .GATE_I(gate), .SLOW_AREA_I(slow), .REF_CLK_I(ref_clk),
		.AUX_I(aux), .AVS_ADDRESS_I(avs_address), .AVS_READ_I(avs_read), .AVS_WRITE_I(avs_write),
		.AVS_WRITEDATA_I(avs_writedata), .AVS_BYTEENABLE_I(avs_be), .AVS_READDATA_O(avs_readdata),
		.AVS_WAITREQUEST_O(avs_waitrequest), .STAMP_PENDING_O(stamp_pending));

	tsc_acq_model i_acq (
		.clk_i(clk), .rst_n_i(rst_n), .quiet_i(quiet), .start_i(start), .sample_en_o(sample_en),
		.trigger_o(trigger), .gate_o(gate), .slow_o(slow), .card_start_o(card_start), .ref_clk_o(ref_clk),
		.aux_o(aux));

	initial begin
		clk = 1'b0;
		forever #20 clk = !clk;
	end

	// Reference model: stamp sees the count before this cycle's update
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			m_cnt = '0;
			m_cmd = '0;
			m_ovf = 1'b0;
			m_ref_q = 1'b0;
			m_gate_q = 1'b0;
			m_stage_t = TIME_RESET;
			m_stage_d = DATE_RESET;
			m_time = TIME_RESET;
			m_date = DATE_RESET;
			m_q.delete();
		end else if (ce) begin
			m_edge = m_cmd[9] ? (ref_clk && !m_ref_q) : (m_cmd[10] && !ref_clk && m_ref_q);
			if (bus_wr && bus_idx == IDX_STATUS && avs_writedata[1]) m_ovf = 1'b0;
			if (m_cmd[2:1] != 2'b00 && (trigger || gate != m_gate_q || (slow && m_cmd[16]))) begin
				if (m_q.size() == 16) m_ovf = 1'b1;
				else m_q.push_back({m_cmd[12] ? aux : 8'h00, m_cnt[55:0]});
			end
			if ((bus_wr && bus_idx == IDX_CMD && avs_writedata[0] && running) || (card_start && m_cmd[2]))
				m_cnt = '0;
			else if (m_edge) m_cnt = {m_cnt[63:32] + 32'h1, 32'h0};
			else if (sample_en) m_cnt = (m_cmd[10:9] != 2'b00) ? {m_cnt[63:32], m_cnt[31:0] + 32'h1} : m_cnt + 64'h1;
			if (bus_wr && bus_idx == IDX_TIME) m_stage_t = avs_writedata;
			if (bus_wr && bus_idx == IDX_DATE) m_stage_d = avs_writedata;
			if (bus_wr && bus_idx == IDX_CMD) begin
				m_cmd = avs_writedata & CMD_STORE_MASK;
				if (avs_writedata[0]) begin
					m_time = m_stage_t & 32'h00ff_ffff;
					m_date = m_stage_d;
				end
			end
			m_ref_q = ref_clk;
			m_gate_q = gate;
		end
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			num_errors++;
			finish_test();
		end
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask

	task automatic rd(input logic [15:0] idx, output logic [31:0] d);
		bus(1'b0, idx, 32'h0, d);
	endtask

	task automatic drain();
		logic [31:0] lo, hi;
		logic [63:0] e;
		while (m_q.size() != 0) begin
			e = m_q.pop_front();
			rd(IDX_STAMP_LO, lo);
			rd(IDX_STAMP_HI, hi);
			`CHK("stamp", e, {hi, lo})
		end
		rd(IDX_STATUS, lo);
		`CHK("status", {30'h0, m_ovf, 1'b1}, lo & 32'h0000_1f03)
		`CHK("pending", 1'b0, stamp_pending)
		wr(IDX_STATUS, 32'h0000_0006);
	endtask

	initial begin
		rst_n = 1'b0;
		running = 1'b1;
		quiet = 1'b1;
		start = 1'b0;
		ce = 1'b1;
		avs_be = 4'hf;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(rst_idx[i], v);
			`CHK("reset value", rst_val[i], v & ((i == 5) ? 32'h0000_1f07 : 32'hffff_ffff))
		end
		wr(IDX_CAPS, 32'h0);
		rd(IDX_CAPS, v);
		`CHK("caps", CAPS_VALUE, v)
		rd(16'h0100, v);
		`CHK("unmapped", 32'h0, v)
		for (int i = 0; i < 7; i++) begin
			wr(IDX_TIME, {8'hff, 8'(i), 8'h2d, 8'h3b});
			wr(IDX_DATE, {16'h07e4, 8'h0c, 8'(i + 1)});
			running <= run[i];
			// Mode, source and features go in one write
			wr(IDX_CMD, cfg[i] | CMD_CLEAR);
			rd(IDX_CMD, v);
			`CHK("cmd", cfg[i] & CMD_STORE_MASK, v)
			rd(IDX_TIME, v);
			`CHK("time", m_time, v)
			rd(IDX_DATE, v);
			`CHK("date", m_date, v)
			quiet <= 1'b0;
			repeat (len[i] / 2) @(posedge clk);
			// Freeze in the last run; events seen meanwhile must leave no trace
			ce <= (i != 6);
			repeat (4) @(posedge clk);
			ce <= 1'b1;
			start <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			repeat (len[i] / 2) @(posedge clk);
			quiet <= 1'b1;
			repeat (3) @(posedge clk);
			`CHK("pending", (m_q.size() != 0), stamp_pending)
			drain();
		end
		wr(IDX_CMD, MODE_EXPLICIT | SRC_SPLIT_RISE);
		// Only byte lane 1 may land
		avs_be <= 4'h2;
		wr(IDX_WAIT_LIMIT, 32'hffff_ffff);
		avs_be <= 4'hf;
		rd(IDX_WAIT_LIMIT, v);
		`CHK("limit lanes", 32'h0000_ff00, v)
		wr(IDX_WAIT_LIMIT, 32'h1);
		rd(IDX_WAIT_LIMIT, v);
		`CHK("limit", 32'h1, v)
		repeat (40) @(posedge clk);
		rd(IDX_STATUS, v);
		`CHK("ref timeout", 1'b1, v[ST_REF_TIMEOUT])
		wr(IDX_WAIT_LIMIT, 32'h0);
		wr(IDX_STATUS, 32'h0000_0004);
		rd(IDX_STATUS, v);
		`CHK("ref timeout clr", 1'b0, v[ST_REF_TIMEOUT])
		finish_test();
	end

	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		finish_test();
	end
endmodule
